// ===== shared/eft_pkg.sv
package eft_pkg;
	localparam int unsigned CLK_HZ      = 10_000_000;
	localparam int unsigned LINE_BPS    = 2_048_000;
	localparam int unsigned FRAME_HZ    = 8_000;
	localparam int unsigned BIT_CELL_NS = 488;
	// fractional bit tick: ACC_STEP line bits every ACC_MOD clocks
	localparam logic [10:0] ACC_STEP    = 11'(LINE_BPS / FRAME_HZ);
	localparam logic [10:0] ACC_MOD     = 11'(CLK_HZ / FRAME_HZ);
	localparam logic [7:0]  FRAME_LAST  = 8'hFF;
	localparam logic [7:0]  SA_FIRST    = 8'h03;
	localparam logic [7:0]  SA_LAST     = 8'h07;
	localparam logic [7:0]  FAS_BYTE    = 8'h9B;
	localparam logic [7:0]  NFAS_BYTE   = 8'hDF;
	localparam logic [1:0]  CAP_DELAY   = 2'h2;
	localparam logic [1:0]  CELL_MIN    = 2'h3;

	localparam logic [5:0]  ADDR_CTRL   = 6'h00;
	localparam logic [5:0]  ADDR_IDLE   = 6'h04;
	localparam logic [5:0]  ADDR_STAT   = 6'h08;
	localparam logic [5:0]  ADDR_IRQ    = 6'h0C;
	localparam logic [5:0]  ADDR_MASK   = 6'h10;
	localparam logic [5:0]  ADDR_LINK   = 6'h14;

	localparam int unsigned CTRL_FAILSEL = 0;
	localparam int unsigned CTRL_SA_LO   = 1;
	localparam logic [5:0]  CTRL_RESET   = 6'h00;
	localparam logic [7:0]  IDLE_RESET   = 8'hD5;
	localparam int unsigned IRQ_FAIL     = 0;
	localparam int unsigned IRQ_AIS      = 1;
	localparam int unsigned IRQ_LINK     = 2;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	typedef enum logic [1:0] {TM_FREE, TM_LINE, TM_BUS} eft_mode_t;
endpackage : eft_pkg

// ===== hdl/eft_core.sv
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module eft_core (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [5:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [5:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        tx_alarm_force_n,
	input  wire logic        signal_loss_status,
	input  wire logic        frame_loss_status,
	input  wire logic        timing_mode_select,
	input  wire logic        bus_or_line_select,
	input  wire logic        tx_link_data,
	output var  logic        tx_link_clock,
	output var  logic        line_fail_out,
	output var  logic        line_out_pos,
	output var  logic        line_out_neg,
	input  wire logic        frame_pulse_n_i,
	output var  logic        frame_pulse_n_o,
	output var  logic        frame_pulse_n_oe,
	output var  logic        irq
);
	typedef struct packed {
		logic [1:0]         ais_s, tm_s, bl_s, dat_s, fp_s;
		logic               fp_d, ais_d;
		eft_pkg::eft_mode_t mode;
		logic [10:0]        acc;
		logic               tick;
		logic [7:0]         bitpos;
		logic               odd;
		logic               ami_neg;
		logic               line_bit;
		logic               pos, neg, fail, lclk, lreq, fp_o, fp_oe;
		logic [1:0]         cap_cnt;
		logic               cap;
		logic               link_bit;
		logic [7:0]         link_hist;
		logic [5:0]         ctrl;
		logic [7:0]         idle;
		logic [2:0]         ists, imask;
		logic               irq;
		logic               aw_full, w_full, awrdy, wrdy, bvalid;
		logic [5:0]         awaddr;
		logic [31:0]        wdata;
		logic [3:0]         wstrb;
		logic [1:0]         bresp;
		logic               arrdy, rvalid;
		logic [31:0]        rdata;
		logic [1:0]         rresp;
	} eft_state_t;

	eft_state_t s_r, s_nxt;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		end
		return r;
	endfunction : merge

	function automatic logic sa_pos(input logic [7:0] p, input logic [4:0] sel);
		logic hit;
		hit = 1'b0;
		if (p >= eft_pkg::SA_FIRST && p <= eft_pkg::SA_LAST)
			hit = sel[3'(p - eft_pkg::SA_FIRST)];
		return hit;
	endfunction : sa_pos

	logic [7:0]  np;
	logic        nodd;
	logic        fbit;
	logic [7:0]  fbyte;
	logic [4:0]  sa_sel;
	logic        fp_fall;
	logic [2:0]  ev;
	logic [31:0] rd;
	logic [1:0]  rr;
	logic [31:0] wv;
	logic        do_wr;

	always_comb
	begin
		s_nxt = s_r;
		// first stage feeds only the second
		s_nxt.ais_s = {s_r.ais_s[0], tx_alarm_force_n};
		s_nxt.tm_s  = {s_r.tm_s[0], timing_mode_select};
		s_nxt.bl_s  = {s_r.bl_s[0], bus_or_line_select};
		s_nxt.dat_s = {s_r.dat_s[0], tx_link_data};
		s_nxt.fp_s  = {s_r.fp_s[0], frame_pulse_n_i};
		s_nxt.fp_d  = s_r.fp_s[1];
		s_nxt.ais_d = s_r.ais_s[1];
		fp_fall     = s_r.fp_d & ~s_r.fp_s[1];
		sa_sel      = s_r.ctrl[eft_pkg::CTRL_SA_LO +: 5];

		if (!s_r.tm_s[1])
			s_nxt.mode = eft_pkg::TM_FREE;
		else if (s_r.bl_s[1])
			s_nxt.mode = eft_pkg::TM_BUS;
		else
			s_nxt.mode = eft_pkg::TM_LINE;
		s_nxt.fp_oe = (s_r.mode != eft_pkg::TM_BUS);

		// line bit cells at 2.048 Mbit/s from the 10 MHz clock
		if (s_r.acc >= eft_pkg::ACC_MOD - eft_pkg::ACC_STEP)
		begin
			s_nxt.acc  = 11'(s_r.acc + eft_pkg::ACC_STEP - eft_pkg::ACC_MOD);
			s_nxt.tick = 1'b1;
		end
		else
		begin
			s_nxt.acc  = 11'(s_r.acc + eft_pkg::ACC_STEP);
			s_nxt.tick = 1'b0;
		end

		np   = 8'(s_r.bitpos + 8'h01);
		nodd = (s_r.bitpos == eft_pkg::FRAME_LAST) ? ~s_r.odd : s_r.odd;
		if (s_r.mode == eft_pkg::TM_BUS && fp_fall)
		begin
			np   = 8'h00;
			nodd = 1'b0;
		end
		fbyte = s_r.odd ? eft_pkg::NFAS_BYTE : eft_pkg::FAS_BYTE;
		if (np < 8'h08)
			fbit = fbyte[3'(7 - np[2:0])];
		else
			fbit = s_r.idle[3'(7 - np[2:0])];
		if (nodd && sa_pos(np, sa_sel))
			fbit = s_r.link_bit;
		if (!s_r.ais_s[1])
			fbit = 1'b1;

		if (s_r.tick)
		begin
			s_nxt.bitpos   = np;
			s_nxt.odd      = nodd;
			s_nxt.line_bit = fbit;
			// AMI: each one alternates polarity, zero drives neither side
			s_nxt.pos      = fbit & ~s_r.ami_neg;
			s_nxt.neg      = fbit & s_r.ami_neg;
			if (fbit)
				s_nxt.ami_neg = ~s_r.ami_neg;
			// low at every cell start so back-to-back national bits still get an edge
			s_nxt.lclk = 1'b0;
			s_nxt.lreq = nodd && sa_pos(8'(np + 8'h01), sa_sel);
			s_nxt.fp_o = ~(np == 8'h00);
		end
		else if (s_r.lreq)
		begin
			s_nxt.lclk = 1'b1;
			s_nxt.lreq = 1'b0;
		end

		// rise of link clock: sample after the two-flop data path
		s_nxt.cap = 1'b0;
		if (s_nxt.lclk && !s_r.lclk)
			s_nxt.cap_cnt = eft_pkg::CAP_DELAY;
		else if (s_r.cap_cnt != 2'h0)
		begin
			s_nxt.cap_cnt = 2'(s_r.cap_cnt - 2'h1);
			if (s_r.cap_cnt == 2'h1)
			begin
				s_nxt.cap       = 1'b1;
				s_nxt.link_bit  = s_r.dat_s[1];
				s_nxt.link_hist = {s_r.link_hist[6:0], s_r.dat_s[1]};
			end
		end

		if (s_r.ctrl[eft_pkg::CTRL_FAILSEL])
			s_nxt.fail = signal_loss_status;
		else
			s_nxt.fail = signal_loss_status | frame_loss_status;

		ev = 3'h0;
		ev[eft_pkg::IRQ_FAIL] = s_nxt.fail & ~s_r.fail;
		ev[eft_pkg::IRQ_AIS]  = ~s_r.ais_s[1] & s_r.ais_d;
		ev[eft_pkg::IRQ_LINK] = s_r.cap;

		// axi write: address and data in either order
		if (s_axi_awvalid && s_r.awrdy)
		begin
			s_nxt.aw_full = 1'b1;
			s_nxt.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.wrdy)
		begin
			s_nxt.w_full = 1'b1;
			s_nxt.wdata  = s_axi_wdata;
			s_nxt.wstrb  = s_axi_wstrb;
		end
		do_wr = s_r.aw_full && s_r.w_full && !s_r.bvalid;
		wv    = 32'h0000_0000;
		if (do_wr)
		begin
			s_nxt.aw_full = 1'b0;
			s_nxt.w_full  = 1'b0;
			s_nxt.bvalid  = 1'b1;
			s_nxt.bresp   = eft_pkg::RESP_OKAY;
			if (s_r.awaddr == eft_pkg::ADDR_CTRL)
			begin
				wv         = merge({26'h0, s_r.ctrl}, s_r.wdata, s_r.wstrb);
				s_nxt.ctrl = wv[5:0];
			end
			else if (s_r.awaddr == eft_pkg::ADDR_IDLE)
			begin
				wv         = merge({24'h0, s_r.idle}, s_r.wdata, s_r.wstrb);
				s_nxt.idle = wv[7:0];
			end
			else if (s_r.awaddr == eft_pkg::ADDR_IRQ)
				wv = merge(32'h0000_0000, s_r.wdata, s_r.wstrb);
			else if (s_r.awaddr == eft_pkg::ADDR_MASK)
			begin
				wv          = merge({29'h0, s_r.imask}, s_r.wdata, s_r.wstrb);
				s_nxt.imask = wv[2:0];
			end
			else if (s_r.awaddr != eft_pkg::ADDR_STAT && s_r.awaddr != eft_pkg::ADDR_LINK)
				s_nxt.bresp = eft_pkg::RESP_SLVERR;
		end
		if (s_r.bvalid && s_axi_bready)
			s_nxt.bvalid = 1'b0;
		// set wins over a clearing write in the same cycle
		s_nxt.ists = (s_r.ists & ~((s_r.awaddr == eft_pkg::ADDR_IRQ && do_wr) ? wv[2:0] : 3'h0))
			| ev;
		s_nxt.irq   = |(s_nxt.ists & s_nxt.imask);
		s_nxt.awrdy = !s_nxt.aw_full;
		s_nxt.wrdy  = !s_nxt.w_full;

		// axi read
		rd = 32'h0000_0000;
		rr = eft_pkg::RESP_OKAY;
		if (s_axi_araddr == eft_pkg::ADDR_CTRL)
			rd[5:0] = s_r.ctrl;
		else if (s_axi_araddr == eft_pkg::ADDR_IDLE)
			rd[7:0] = s_r.idle;
		else if (s_axi_araddr == eft_pkg::ADDR_STAT)
			rd[6:0] = {s_r.mode, s_r.odd, s_r.fail, ~s_r.ais_s[1], frame_loss_status,
				signal_loss_status};
		else if (s_axi_araddr == eft_pkg::ADDR_IRQ)
			rd[2:0] = s_r.ists;
		else if (s_axi_araddr == eft_pkg::ADDR_MASK)
			rd[2:0] = s_r.imask;
		else if (s_axi_araddr == eft_pkg::ADDR_LINK)
			rd[7:0] = s_r.link_hist;
		else
			rr = eft_pkg::RESP_SLVERR;
		if (s_axi_arvalid && s_r.arrdy)
		begin
			s_nxt.arrdy  = 1'b0;
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata  = rd;
			s_nxt.rresp  = rr;
		end
		else if (s_r.rvalid && s_axi_rready)
		begin
			s_nxt.rvalid = 1'b0;
			s_nxt.arrdy  = 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_r        <= '0;
			s_r.ais_s  <= 2'h3;
			s_r.fp_s   <= 2'h3;
			s_r.fp_d   <= 1'b1;
			s_r.ais_d  <= 1'b1;
			s_r.fp_o   <= 1'b1;
			s_r.fp_oe  <= 1'b1;
			s_r.mode   <= eft_pkg::TM_FREE;
			s_r.ctrl   <= eft_pkg::CTRL_RESET;
			s_r.idle   <= eft_pkg::IDLE_RESET;
			s_r.awrdy  <= 1'b1;
			s_r.wrdy   <= 1'b1;
			s_r.arrdy  <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	assign s_axi_awready    = s_r.awrdy;
	assign s_axi_wready     = s_r.wrdy;
	assign s_axi_bvalid     = s_r.bvalid;
	assign s_axi_bresp      = s_r.bresp;
	assign s_axi_arready    = s_r.arrdy;
	assign s_axi_rvalid     = s_r.rvalid;
	assign s_axi_rdata      = s_r.rdata;
	assign s_axi_rresp      = s_r.rresp;
	assign tx_link_clock    = s_r.lclk;
	assign line_fail_out    = s_r.fail;
	assign line_out_pos     = s_r.pos;
	assign line_out_neg     = s_r.neg;
	assign frame_pulse_n_o  = s_r.fp_o;
	assign frame_pulse_n_oe = s_r.fp_oe;
	assign irq              = s_r.irq;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence link_rise;
		!s_r.lclk ##1 s_r.lclk;
	endsequence
	sequence sampled_bit;
		##2 s_r.cap && s_r.link_bit == $past(s_r.dat_s[1]);
	endsequence

	a_ais_ones: assert property (s_r.tick && !s_r.ais_s[1] |=> s_r.pos ^ s_r.neg)
		else $error("alarm forced but line bit not a one");
	a_fail_either: assert property (!s_r.ctrl[0] && (signal_loss_status || frame_loss_status)
		|=> line_fail_out)
		else $error("fail output low while a loss is reported");
	a_fail_sig_only: assert property (s_r.ctrl[0] && !signal_loss_status |=> !line_fail_out)
		else $error("fail output high without signal loss");
	a_link_gap: assert property (link_rise |-> s_r.odd && s_r.bitpos >= 8'h02
		&& s_r.bitpos <= 8'h06 ##1 s_r.lclk[*2])
		else $error("link clock outside national cells or too short");
	a_link_sample: assert property (link_rise |-> sampled_bit)
		else $error("link bit not captured two cycles after rise");
	a_sa_insert: assert property (s_r.tick && s_r.ais_s[1] && nodd && sa_pos(np, sa_sel)
		|=> s_r.line_bit == $past(s_r.link_bit))
		else $error("national bit not taken from link data");
	a_mode_free: assert property (!s_r.tm_s[1] |=> s_r.mode == eft_pkg::TM_FREE)
		else $error("timing input low but not free-run");
	a_fp_dir: assert property (s_r.mode == eft_pkg::TM_BUS |=> !frame_pulse_n_oe)
		else $error("frame pulse driven in bus sync");
	a_sync_depth: assert property (s_r.ais_s[1] == $past(tx_alarm_force_n, 2)
		|| $past(!aresetn, 2))
		else $error("alarm input not delayed by two flops");
endmodule : eft_core
`default_nettype wire

// ===== testbench/eft_partner.sv
`timescale 1ns/10ps
`default_nettype none
module eft_partner (
	input  wire logic       aclk,
	input  wire logic       tx_link_clock,
	output var  logic       tx_link_data,
	output var  logic       frame_pulse_n,
	output var  logic [7:0] sent_bits
);
	logic [15:0] pat_r  = 16'hC53A;
	logic        lclk_r = 1'b0;
	logic [10:0] fcnt_r = 11'h000;
	initial tx_link_data = 1'b0;
	initial frame_pulse_n = 1'b1;
	initial sent_bits = 8'h00;
	// next bit goes out just after a rise, so it stands a whole period before the next rise
	always @(posedge aclk)
	begin
		lclk_r <= tx_link_clock;
		if (tx_link_clock && !lclk_r)
		begin
			sent_bits    <= {sent_bits[6:0], tx_link_data};
			pat_r        <= {pat_r[14:0], pat_r[15]};
			tx_link_data <= pat_r[15];
		end
		// frame start every 1250 clocks, only heard in bus sync
		fcnt_r        <= (fcnt_r == 11'h4E1) ? 11'h000 : fcnt_r + 11'h001;
		frame_pulse_n <= (fcnt_r != 11'h000);
	end
endmodule : eft_partner
`default_nettype wire

// ===== testbench/eft_core_bench.sv
`timescale 1ns/10ps
`default_nettype none
module eft_core_bench;
	logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        tx_alarm_force_n = 1'b1, signal_loss_status = 1'b0, frame_loss_status = 1'b0;
	logic        timing_mode_select = 1'b0, bus_or_line_select = 1'b0;
	logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        tx_link_data, tx_link_clock, line_fail_out, line_out_pos, line_out_neg;
	logic        frame_pulse_n_i, frame_pulse_n_o, frame_pulse_n_oe, irq, fp_ext;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_rdata, rd;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [7:0]  sent_bits;
	int          compares = 0, miscompares = 0;
	assign frame_pulse_n_i = frame_pulse_n_oe ? frame_pulse_n_o : fp_ext;
	eft_core eft_core_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_alarm_force_n, .signal_loss_status,
		.frame_loss_status, .timing_mode_select, .bus_or_line_select, .tx_link_data,
		.tx_link_clock, .line_fail_out, .line_out_pos, .line_out_neg, .frame_pulse_n_i,
		.frame_pulse_n_o, .frame_pulse_n_oe, .irq);
	eft_partner eft_partner_inst (.aclk, .tx_link_clock, .tx_link_data,
		.frame_pulse_n(fp_ext), .sent_bits);
	initial
	begin
		forever #50 aclk = ~aclk;
	end
	task automatic summarize;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	task automatic chk(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1)
		begin
			miscompares++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask : chk
	task automatic axi_wr(input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1 && n < 50);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 50)
		begin
			miscompares++;
			summarize();
		end
	endtask : axi_wr
	task automatic axi_rd(input logic [5:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1 && n < 50);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 50)
		begin
			miscompares++;
			summarize();
		end
	endtask : axi_rd
	task automatic t_reset;
		chk(line_out_pos === 1'b0 && line_out_neg === 1'b0 && tx_link_clock === 1'b0, "idle");
		chk(frame_pulse_n_oe === 1'b1 && irq === 1'b0 && line_fail_out === 1'b0, "rst");
		axi_rd(6'h3C);
		chk(rsp === eft_pkg::RESP_SLVERR, "unmapped read");
		axi_wr(6'h3C, 32'h0000_0001);
		chk(rsp === eft_pkg::RESP_SLVERR, "unmapped write");
		axi_rd(eft_pkg::ADDR_IDLE);
		chk(rd[7:0] === eft_pkg::IDLE_RESET, "idle reset value");
	endtask : t_reset
	task automatic t_fail;
		for (int k = 0; k < 8; k++)
		begin
			axi_wr(eft_pkg::ADDR_CTRL, 32'(k[2]));
			chk(rsp === eft_pkg::RESP_OKAY, "ctrl write response");
			signal_loss_status <= k[0];
			frame_loss_status  <= k[1];
			repeat (3) @(posedge aclk);
			chk(line_fail_out === (k[2] ? k[0] : k[0] | k[1]), "fail out");
		end
	endtask : t_fail
	task automatic t_alarm;
		chk(irq === 1'b0, "masked irq");
		axi_wr(eft_pkg::ADDR_MASK, 32'h0000_0002);
		tx_alarm_force_n <= 1'b0;
		repeat (10) @(posedge aclk);
		for (int k = 0; k < 40; k++)
		begin
			@(posedge aclk);
			chk((line_out_pos ^ line_out_neg) === 1'b1, "all ones");
		end
		chk(irq === 1'b1, "alarm irq");
		axi_rd(eft_pkg::ADDR_STAT);
		chk(rd[2] === 1'b1, "alarm status");
		axi_wr(eft_pkg::ADDR_IRQ, 32'h0000_0002);
		repeat (2) @(posedge aclk);
		chk(irq === 1'b0, "irq cleared");
		tx_alarm_force_n <= 1'b1;
	endtask : t_alarm
	task automatic t_timing;
		for (int k = 0; k < 4; k++)
		begin
			@(posedge aclk);
			timing_mode_select <= (k == 1 || k == 2);
			bus_or_line_select <= (k != 1);
			repeat (2) @(posedge aclk);
			#1;
			if (k == 2) chk(frame_pulse_n_oe === 1'b1, "sync delay");
			repeat (3) @(posedge aclk);
			chk(frame_pulse_n_oe === (k != 2), "pulse direction");
			axi_rd(eft_pkg::ADDR_STAT);
			chk(rd[6:5] === 2'(k % 3), "timing mode");
		end
	endtask : t_timing
	task automatic t_rate;
		int rises, hi, falls;
		logic prev, fprev;
		for (int n = 1; n <= 5; n++)
		begin
			axi_wr(eft_pkg::ADDR_CTRL, 32'(((1 << n) - 1) << 1));
			rises = 0;
			hi = 0;
			falls = 0;
			prev = tx_link_clock;
			fprev = frame_pulse_n_o;
			// a 5000 clock window holds four frames, two of them odd
			repeat (5000)
			begin
				@(posedge aclk);
				if (tx_link_clock === 1'b1) hi++;
				else if (prev === 1'b1)
				begin
					if (rises > 0) chk(hi == 3 || hi == 4, "link clock width");
					hi = 0;
				end
				if (tx_link_clock === 1'b1 && prev !== 1'b1) rises++;
				prev = tx_link_clock;
				if (frame_pulse_n_o === 1'b0 && fprev === 1'b1) falls++;
				fprev = frame_pulse_n_o;
			end
			chk(rises == 2 * n, "link clock rate");
			chk(falls == 4, "frame pulse rate");
		end
	endtask : t_rate
	task automatic t_link;
		int n, lo;
		logic seen;
		n = 0;
		lo = 0;
		seen = 1'b0;
		// read only in the long quiet after a burst, so no capture races the read
		while (!(seen && lo >= 20) && n < 3000)
		begin
			@(posedge aclk);
			n++;
			seen = seen | (tx_link_clock === 1'b1);
			lo = (tx_link_clock === 1'b1) ? 0 : lo + 1;
		end
		if (n >= 3000) chk(1'b0, "no link burst");
		axi_rd(eft_pkg::ADDR_LINK);
		chk(rd[7:0] === sent_bits, "link bits");
	endtask : t_link
	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_fail();
		t_alarm();
		t_timing();
		t_rate();
		t_link();
		summarize();
	end
endmodule : eft_core_bench
`default_nettype wire
